// ---- hdl/acsp_amp_config.sv ----
// configuration port of a programmable-gain amplifier, serial or parallel
`timescale 1ns/10ps
`default_nettype none
`include "acsp_consts.svh"

module acsp_amp_config
   import acsp_pkg::*;
(
   // core clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // serial link
   input wire logic i_sclk,
   input wire logic i_select_n,
   input wire logic i_serial_in,
   output logic o_serial_out,
   output logic o_serial_out_oe,
   // mode level pins
   input wire logic i_level_select_a,
   input wire logic i_level_select_b,
   // parallel pins
   input wire logic [2:0] i_gain_pin,
   input wire logic i_power_down,
   // amplifier settings
   output logic o_parallel_mode,
   output logic [2:0] o_gain,
   output logic o_ext_gain,
   output logic [2:0] o_comp,
   output logic [2:0] o_comp_level,
   output logic [1:0] o_input_select,
   output logic o_input_invert,
   output logic o_shutdown,
   output logic o_ext_cap_filter_en,
   output logic o_fault_pin_sel,
   output logic [2:0] o_fault_test_current
);

   localparam acsp_core_s CORE_RST = '{
      sel_n_s1: 1'b1,
      sel_n_s2: 1'b1,
      lvl_a_s1: 1'b0,
      lvl_a_s2: 1'b0,
      lvl_b_s1: 1'b0,
      lvl_b_s2: 1'b0,
      gain_s1: 3'h0,
      gain_s2: 3'h0,
      pd_s1: 1'b0,
      pd_s2: 1'b0,
      state: ACSP_ST_IDLE,
      hold: `ACSP_WORD_RST,
      parallel: 1'b0,
      gain: 3'h0,
      comp: 3'h0,
      comp_level: 3'h0,
      ext_gain: 1'b0,
      mux: 2'h0,
      invert: 1'b0,
      power_down: 1'b0,
      ext_cap_filter_en: 1'b0,
      fpin: 1'b0,
      cur: 3'h0
   };

   acsp_core_s r;
   acsp_core_s n;
   logic [`ACSP_WORD_W-1:0] shift_word;
   logic w_parallel;

   // link-side shift register, clocked by the serial clock
   acsp_shifter #(
      .WORD_W(`ACSP_WORD_W)
   ) u_shifter (
      .i_sclk(i_sclk),
      .i_rst(i_rst),
      .i_select_n(i_select_n),
      .i_serial_in(i_serial_in),
      .o_serial_out(o_serial_out),
      .o_serial_out_oe(o_serial_out_oe),
      .o_word(shift_word)
   );

   // compensation chosen from the parallel gain code
   function automatic logic [2:0] auto_comp(input logic [2:0] g);
      logic [2:0] c;
      case (g)
         3'h0, 3'h1: c = `ACSP_COMP_L0;
         3'h2: c = `ACSP_COMP_L1;
         3'h3, 3'h4: c = `ACSP_COMP_L2;
         3'h5, 3'h6: c = `ACSP_COMP_L3;
         default: c = `ACSP_COMP_L4;
      endcase
      return c;
   endfunction

   // mode: level a low with b high is serial, the reverse is parallel
   assign w_parallel = r.lvl_a_s2 & ~r.lvl_b_s2;

   // next state of the core domain
   always_comb begin
      n = r;
      // two-flop synchronisers for every pin read here
      n.sel_n_s1 = i_select_n;
      n.sel_n_s2 = r.sel_n_s1;
      n.lvl_a_s1 = i_level_select_a;
      n.lvl_a_s2 = r.lvl_a_s1;
      n.lvl_b_s1 = i_level_select_b;
      n.lvl_b_s2 = r.lvl_b_s1;
      n.gain_s1 = i_gain_pin;
      n.gain_s2 = r.gain_s1;
      n.pd_s1 = i_power_down;
      n.pd_s2 = r.pd_s1;

      // frame tracking; the word is quiet once select is high again
      case (r.state)
         ACSP_ST_IDLE: begin
            if (!r.sel_n_s2) begin
               n.state = ACSP_ST_FRAME;
            end
         end
         ACSP_ST_FRAME: begin
            if (r.sel_n_s2) begin
               n.state = ACSP_ST_IDLE;
               n.hold = shift_word;
            end
         end
         default: begin
            n.state = ACSP_ST_IDLE;
         end
      endcase

      // settings: gain and power down pins in parallel mode, compensation from the gain code, the other fields cleared; holding word in serial mode
      n.parallel = w_parallel;
      if (w_parallel) begin
         n.gain = r.gain_s2;
         n.comp = auto_comp(r.gain_s2);
         n.power_down = r.pd_s2;
         n.mux = 2'h0;
         n.invert = 1'b0;
         n.ext_cap_filter_en = 1'b0;
         n.fpin = 1'b0;
         n.cur = 3'h0;
      end else begin
         n.gain = r.hold[`ACSP_GAIN_MSB:`ACSP_GAIN_LSB];
         n.comp = r.hold[`ACSP_COMP_MSB:`ACSP_COMP_LSB];
         n.mux = r.hold[`ACSP_MUX_MSB:`ACSP_MUX_LSB];
         n.invert = r.hold[`ACSP_INV_BIT];
         n.power_down = r.hold[`ACSP_POWER_DOWN_BIT];
         n.ext_cap_filter_en = r.hold[`ACSP_EXT_CAP_FILTER_EN_BIT];
         n.fpin = r.hold[`ACSP_FPIN_BIT];
         n.cur = r.hold[`ACSP_CUR_MSB:`ACSP_CUR_LSB];
      end
      // top word bit is stored but drives nothing
      n.ext_gain = (n.gain == `ACSP_GAIN_EXT);
      n.comp_level = n.comp[2] ? `ACSP_COMP_L4 : {1'b0, n.comp[1:0]};
   end

   // single state register; holding word clears at reset
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         r <= CORE_RST;
      end else begin
         r <= n;
      end
   end

   // outputs straight from flops
   assign o_parallel_mode = r.parallel;
   assign o_gain = r.gain;
   assign o_ext_gain = r.ext_gain;
   assign o_comp = r.comp;
   assign o_comp_level = r.comp_level;
   assign o_input_select = r.mux;
   assign o_input_invert = r.invert;
   assign o_shutdown = r.power_down;
   assign o_ext_cap_filter_en = r.ext_cap_filter_en;
   assign o_fault_pin_sel = r.fpin;
   assign o_fault_test_current = r.cur;

   // checks on the core clock
   property p_load;
      @(posedge i_core_clk) disable iff (i_rst)
      (r.state == ACSP_ST_FRAME && r.sel_n_s2) |=>
         (r.hold == $past(shift_word));
   endproperty
   a_load: assert property (p_load)
      else $error("holding word not loaded at end of frame");

   property p_no_load_idle;
      @(posedge i_core_clk) disable iff (i_rst)
      (r.state == ACSP_ST_IDLE) |=> $stable(r.hold);
   endproperty
   a_no_load_idle: assert property (p_no_load_idle)
      else $error("holding word changed outside a frame end");

   property p_mode;
      @(posedge i_core_clk) disable iff (i_rst)
      (r.lvl_a_s2 && !r.lvl_b_s2) [*2] |-> o_parallel_mode;
   endproperty
   a_mode: assert property (p_mode)
      else $error("parallel mode not taken");

   property p_par_gain;
      @(posedge i_core_clk) disable iff (i_rst)
      w_parallel |=> (o_gain == $past(r.gain_s2)) &&
                     (o_comp == auto_comp($past(r.gain_s2)));
   endproperty
   a_par_gain: assert property (p_par_gain)
      else $error("parallel gain or compensation wrong");

   property p_par_comp3;
      @(posedge i_core_clk) disable iff (i_rst)
      (w_parallel && r.gain_s2 == 3'h3) |=> (o_comp == `ACSP_COMP_L2);
   endproperty
   a_par_comp3: assert property (p_par_comp3)
      else $error("parallel compensation for gain code 3 wrong");

   property p_par_power_down;
      @(posedge i_core_clk) disable iff (i_rst)
      w_parallel |=> (o_shutdown == $past(r.pd_s2));
   endproperty
   a_par_power_down: assert property (p_par_power_down)
      else $error("parallel shutdown does not follow pin");

   property p_par_fault;
      @(posedge i_core_clk) disable iff (i_rst)
      w_parallel |=> (o_fault_test_current == 3'h0) &&
                     !o_ext_cap_filter_en && !o_fault_pin_sel;
   endproperty
   a_par_fault: assert property (p_par_fault)
      else $error("fault features active in parallel mode");

   property p_ser_low;
      @(posedge i_core_clk) disable iff (i_rst)
      !w_parallel |=> (o_gain == $past(r.hold[2:0])) &&
                      (o_comp == $past(r.hold[5:3])) &&
                      (o_input_select == $past(r.hold[7:6])) &&
                      (o_input_invert == $past(r.hold[8]));
   endproperty
   a_ser_low: assert property (p_ser_low)
      else $error("serial gain, compensation or input fields wrong");

   property p_ser_high;
      @(posedge i_core_clk) disable iff (i_rst)
      !w_parallel |=> (o_shutdown == $past(r.hold[9])) &&
                      (o_ext_cap_filter_en == $past(r.hold[10])) &&
                      (o_fault_pin_sel == $past(r.hold[11])) &&
                      (o_fault_test_current == $past(r.hold[14:12]));
   endproperty
   a_ser_high: assert property (p_ser_high)
      else $error("serial shutdown, filter or fault fields wrong");

   property p_decode;
      @(posedge i_core_clk) disable iff (i_rst)
      o_comp[2] |-> (o_comp_level == `ACSP_COMP_L4) ##0
         (o_ext_gain == (o_gain == 3'h7));
   endproperty
   a_decode: assert property (p_decode)
      else $error("compensation level or external gain decode wrong");

   property p_cov_load;
      @(posedge i_core_clk) disable iff (i_rst)
      (r.state == ACSP_ST_FRAME && r.sel_n_s2 && !w_parallel);
   endproperty
   c_load: cover property (p_cov_load);

   property p_cov_par_ext;
      @(posedge i_core_clk) disable iff (i_rst)
      o_parallel_mode && o_ext_gain;
   endproperty
   c_par_ext: cover property (p_cov_par_ext);

endmodule

`default_nettype wire

// ---- hdl/acsp_consts.svh ----
// constants of the amplifier configuration port: field positions, resets
`ifndef ACSP_CONSTS_SVH
`define ACSP_CONSTS_SVH

`define ACSP_WORD_W 16
`define ACSP_WORD_RST 16'h0000
`define ACSP_GAIN_LSB 0
`define ACSP_GAIN_MSB 2
`define ACSP_COMP_LSB 3
`define ACSP_COMP_MSB 5
`define ACSP_MUX_LSB 6
`define ACSP_MUX_MSB 7
`define ACSP_INV_BIT 8
`define ACSP_POWER_DOWN_BIT 9
`define ACSP_EXT_CAP_FILTER_EN_BIT 10
`define ACSP_FPIN_BIT 11
`define ACSP_CUR_LSB 12
`define ACSP_CUR_MSB 14
`define ACSP_UNUSED_BIT 15
`define ACSP_GAIN_EXT 3'h7
`define ACSP_COMP_L0 3'h0
`define ACSP_COMP_L1 3'h1
`define ACSP_COMP_L2 3'h2
`define ACSP_COMP_L3 3'h3
`define ACSP_COMP_L4 3'h4

`endif

// ---- hdl/acsp_pkg.sv ----
// types of the amplifier configuration port
`include "acsp_consts.svh"

package acsp_pkg;

   typedef enum logic [1:0] {
      ACSP_ST_IDLE = 2'b00,
      ACSP_ST_FRAME = 2'b01
   } acsp_state_e;

   typedef struct packed {
      logic [`ACSP_WORD_W-1:0] word;
   } acsp_shift_s;

   typedef struct packed {
      logic sel_n_s1;
      logic sel_n_s2;
      logic lvl_a_s1;
      logic lvl_a_s2;
      logic lvl_b_s1;
      logic lvl_b_s2;
      logic [2:0] gain_s1;
      logic [2:0] gain_s2;
      logic pd_s1;
      logic pd_s2;
      acsp_state_e state;
      logic [`ACSP_WORD_W-1:0] hold;
      logic parallel;
      logic [2:0] gain;
      logic [2:0] comp;
      logic [2:0] comp_level;
      logic ext_gain;
      logic [1:0] mux;
      logic invert;
      logic power_down;
      logic ext_cap_filter_en;
      logic fpin;
      logic [2:0] cur;
   } acsp_core_s;

endpackage

// ---- hdl/acsp_shifter.sv ----
// serial-clock side: the input shift register and the data output
`timescale 1ns/10ps
`default_nettype none
`include "acsp_consts.svh"

module acsp_shifter
   import acsp_pkg::*;
#(
   parameter int WORD_W = `ACSP_WORD_W
) (
   // link clock and reset
   input wire logic i_sclk,
   input wire logic i_rst,
   // serial pins
   input wire logic i_select_n,
   input wire logic i_serial_in,
   output logic o_serial_out,
   output logic o_serial_out_oe,
   // word toward the core domain
   output logic [WORD_W-1:0] o_word
);

   generate
      if (WORD_W != `ACSP_WORD_W) begin : g_bad_width
         $error("acsp_shifter: WORD_W must equal the control word width");
      end
   endgenerate

   acsp_shift_s sh_reg;
   acsp_shift_s sh_next;

   // shift only while selected; oldest bits fall off the top
   always_comb begin
      sh_next = sh_reg;
      if (!i_select_n) begin
         sh_next.word = {sh_reg.word[WORD_W-2:0], i_serial_in};
      end
   end

   // sclk is high at both chip select edges, so no edge lands outside
   always_ff @(posedge i_sclk or posedge i_rst) begin
      if (i_rst) begin
         sh_reg <= '{word: `ACSP_WORD_RST};
      end else begin
         sh_reg <= sh_next;
      end
   end

   // far end of the register goes out; driver only while selected
   assign o_serial_out = sh_reg.word[WORD_W-1];
   assign o_serial_out_oe = ~i_select_n;
   assign o_word = sh_reg.word;

   // checks on the link clock
   property p_shift_in;
      @(posedge i_sclk) disable iff (i_rst)
      !i_select_n |=> (o_word == {$past(o_word[WORD_W-2:0]),
                                  $past(i_serial_in)});
   endproperty
   a_shift_in: assert property (p_shift_in)
      else $error("serial input bit not shifted in");

   property p_idle_hold;
      @(posedge i_sclk) disable iff (i_rst)
      i_select_n |=> $stable(o_word);
   endproperty
   a_idle_hold: assert property (p_idle_hold)
      else $error("shift register moved while deselected");

   property p_out_order;
      @(posedge i_sclk) disable iff (i_rst)
      !i_select_n |=> (o_serial_out == $past(o_word[WORD_W-2]));
   endproperty
   a_out_order: assert property (p_out_order)
      else $error("serial output not the bit leaving the register");

   property p_long_frame;
      @(posedge i_sclk) disable iff (i_rst)
      !i_select_n [*8];
   endproperty
   c_long_frame: cover property (p_long_frame);

endmodule

`default_nettype wire

// ---- tb/acsp_host_model.sv ----
// host model: drives select, serial clock and data into the port
`timescale 1ns/10ps
`default_nettype none

module acsp_host_model (
   // serial pins toward the device
   output logic o_sclk,
   output logic o_select_n,
   output logic o_serial_in,
   // resolved serial output pin
   input wire logic i_serial_out
);
   // idle: clock parked high, deselected
   initial begin
      o_sclk = 1'b1;
      o_select_n = 1'b1;
      o_serial_in = 1'b0;
   end

   // one frame, msb first; samples the pin just before each rise
   task automatic frame(input logic [31:0] d, input int n,
                        output logic [31:0] so);
      so = 32'h0;
      #5 o_select_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         #16 o_sclk = 1'b0;
         o_serial_in = d[i];
         #16 so = {so[30:0], i_serial_out};
         o_sclk = 1'b1;
      end
      #16 o_select_n = 1'b1;
      // released line must not keep the last bit
      o_serial_in = ~o_serial_in;
   endtask

   // clock pulses meant for another device sharing the clock; select high
   task automatic idle_clocks(input int n);
      for (int i = 0; i < n; i++) begin
         #16 o_sclk = 1'b0;
         #16 o_sclk = 1'b1;
      end
   endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench of the amplifier configuration port
`timescale 1ns/10ps
`default_nettype none

module tb_top;
   logic i_core_clk = 1'b0;
   logic i_rst, i_level_select_a, i_level_select_b, i_power_down;
   logic [2:0] i_gain_pin;
   logic sclk, sel_n, serial_in, o_serial_out, o_serial_out_oe;
   logic o_parallel_mode, o_ext_gain, o_input_invert, o_shutdown;
   logic o_ext_cap_filter_en, o_fault_pin_sel;
   logic [2:0] o_gain, o_comp, o_comp_level, o_fault_test_current;
   logic [1:0] o_input_select;
   logic [15:0] sr;
   logic [31:0] r;
   int err_count = 0;
   int n_tests = 0;
   wire logic sdo_pin;
   wire logic [19:0] got;

   // pin floats when the device lets go of it
   assign sdo_pin = o_serial_out_oe ? o_serial_out : 1'bz;
   assign got = {o_parallel_mode, o_gain, o_ext_gain, o_comp,
      o_comp_level, o_input_select, o_input_invert, o_shutdown,
      o_ext_cap_filter_en, o_fault_pin_sel, o_fault_test_current};

   always #5 i_core_clk = ~i_core_clk;

   acsp_amp_config i_acsp_amp_config (
      .i_core_clk(i_core_clk), .i_rst(i_rst), .i_sclk(sclk),
      .i_select_n(sel_n), .i_serial_in(serial_in),
      .o_serial_out(o_serial_out), .o_serial_out_oe(o_serial_out_oe),
      .i_level_select_a(i_level_select_a),
      .i_level_select_b(i_level_select_b),
      .i_gain_pin(i_gain_pin), .i_power_down(i_power_down),
      .o_parallel_mode(o_parallel_mode), .o_gain(o_gain),
      .o_ext_gain(o_ext_gain), .o_comp(o_comp),
      .o_comp_level(o_comp_level), .o_input_select(o_input_select),
      .o_input_invert(o_input_invert), .o_shutdown(o_shutdown),
      .o_ext_cap_filter_en(o_ext_cap_filter_en),
      .o_fault_pin_sel(o_fault_pin_sel),
      .o_fault_test_current(o_fault_test_current));

   acsp_host_model host (.o_sclk(sclk), .o_select_n(sel_n),
      .o_serial_in(serial_in), .i_serial_out(sdo_pin));

   // settings expected from a serial word
   function automatic logic [19:0] exp_ser(logic [15:0] w);
      logic [2:0] c;
      c = w[5:3];
      return {1'b0, w[2:0], w[2:0] == 3'h7, c, c[2] ? 3'h4 : c,
         w[7:6], w[8], w[9], w[10], w[11], w[14:12]};
   endfunction

   // settings expected from the parallel pins
   function automatic logic [19:0] exp_par(logic [2:0] g, logic pd);
      logic [2:0] c;
      c = (g < 3'h2) ? 3'h0 : (g == 3'h2) ? 3'h1 : (g < 3'h5) ? 3'h2 :
         (g < 3'h7) ? 3'h3 : 3'h4;
      return {1'b1, g, g == 3'h7, c, c, 2'h0, 1'b0, pd, 5'h0};
   endfunction

   task automatic chk_set(input logic [19:0] g, input logic [19:0] e);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %0t settings %h exp %h", $time, g, e);
      end
   endtask

   task automatic chk_bits(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %0t serial %h exp %h", $time, g, e);
      end
   endtask

   // one frame of n bits; tracks the shift register for expectations
   task automatic send(input logic [31:0] d, input int n);
      logic [31:0] so, eo;
      eo = 32'h0;
      for (int i = n - 1; i >= 0; i--) begin
         eo = {eo[30:0], sr[15]};
         sr = {sr[14:0], d[i]};
      end
      @(posedge i_core_clk);
      #1 host.frame(d, n, so);
      chk_bits(so, eo);
      repeat (8) @(posedge i_core_clk);
      #1 chk_bits({31'h0, o_serial_out_oe}, 32'h0);
   endtask

   task automatic print_verdict;
      if (err_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // watchdog against a hung run
   initial begin
      #500000;
      err_count++;
      print_verdict;
   end

   initial begin
      i_rst = 1'b1;
      i_level_select_a = 1'b0;
      i_level_select_b = 1'b1;
      i_gain_pin = 3'h0;
      i_power_down = 1'b0;
      sr = 16'h0;
      void'($urandom(32'h7635));
      repeat (16) @(posedge i_core_clk);
      #1 i_rst = 1'b0;
      repeat (4) @(posedge i_core_clk);
      #1 chk_set(got, 20'h0);
      // every gain and compensation code, random upper fields
      for (int i = 0; i < 8; i++) begin
         r = $urandom;
         send({17'h0, r[14:6], i[2:0], i[2:0]}, 16);
         chk_set(got, exp_ser(sr));
      end
      // host keeps the top bit of the word clear even in a long frame
      send($urandom & 32'hffff7fff, 20);
      chk_set(got, exp_ser(sr));
      send($urandom, 8);
      chk_set(got, exp_ser(sr));
      // shared clock runs for another device; this one must not shift
      host.idle_clocks(12);
      @(posedge i_core_clk);
      #1 chk_set(got, exp_ser(sr));
      // parallel mode: pins rule, word ignored
      i_level_select_a = 1'b1;
      i_level_select_b = 1'b0;
      for (int i = 0; i < 8; i++) begin
         r = $urandom;
         i_gain_pin = i[2:0];
         i_power_down = r[0];
         repeat (5) @(posedge i_core_clk);
         #1 chk_set(got, exp_par(i_gain_pin, i_power_down));
      end
      r = $urandom;
      send({16'h0, 1'b0, r[14:0]}, 16);
      chk_set(got, exp_par(i_gain_pin, i_power_down));
      // back to serial: the word loaded meanwhile takes over
      i_level_select_a = 1'b0;
      i_level_select_b = 1'b1;
      repeat (5) @(posedge i_core_clk);
      #1 chk_set(got, exp_ser(sr));
      print_verdict;
   end
endmodule
`default_nettype wire
